// >>> bench/clk_oe_prog_test.sv
// self-checking bench for the clock output enable programming block
`timescale 1ns/1ps
module clk_oe_prog_test;
  localparam time DLY = 1ns;
  logic                       sys_clk = 1'b0;
  logic                       nrst = 1'b0;
  logic                       ref_clk = 1'b0;
  logic                       sel = 1'b0;
  logic [7:0]                 pin_n = 8'h00;
  logic [7:0]                 hw_oe_n;
  logic [7:0]                 reg_rdata;
  logic [19:0]                oe;
  clk_oe_pkg::reg_req_t       reg_req = '0;
  clk_oe_pkg::sideband_pins_t sb;
  int                         err_total = 0;
  int                         total_checks = 0;

  always #5 sys_clk = ~sys_clk;
  always #7 ref_clk = ~ref_clk;
  // sideband lines take over three enable pins only when selected
  assign hw_oe_n = sel ? {pin_n[7:6], sb.shift_load_n, pin_n[4:2],
                          sb.clk, sb.data} : pin_n;

  clk_oe_prog uut (
    .sys_clk(sys_clk), .nrst(nrst), .ref_clk(ref_clk),
    .interface_select_pin(sel), .hw_oe_n(hw_oe_n), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .clock_output_channel(oe)
  );
  sb_ctrl_model sbm (.sb(sb));

  task automatic test_done;
    $display("checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: byte %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_oe(input logic [19:0] exp);
    total_checks++;
    if (oe !== exp) begin
      err_total++;
      $display("wrong value at %0t: enables %h want %h", $time, oe, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk) #DLY;
    reg_req = '{wr_en: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk) #DLY;
    reg_req.wr_en = 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, exp);
    @(posedge sys_clk) #DLY;
    reg_req.addr = a;
    @(posedge sys_clk) #DLY;
    chk_byte(reg_rdata, exp);
  endtask

  // pins sync and output gating need a few cycles
  task automatic settle;
    repeat (20) @(posedge sys_clk);
    #DLY;
  endtask

  function automatic logic [19:0] exp_reg(input logic [7:0] b0, b1, b2,
                                          input logic [7:0] pins);
    logic [19:0] e;
    e = {b0[6:3], b2, b1};
    for (int i = 0; i < 8; i++) if (pins[i]) e[i+5] = 1'b0;
    return e;
  endfunction

  task automatic t_reset;
    rdc(8'h00, 8'h78);
    rdc(8'h01, 8'hff);
    rdc(8'h02, 8'hff);
    rdc(8'h07, 8'h08);
    rdc(8'h05, clk_oe_pkg::VDR_REV_VAL);
    rdc(8'h06, clk_oe_pkg::DEV_ID_VAL);
    rdc(8'h08, 8'h00);
    rdc(8'h0a, 8'h00);
    settle;
    chk_oe(20'hfffff);
  endtask

  task automatic t_regs;
    wr(8'h00, 8'hff);
    rdc(8'h00, 8'h78);
    wr(8'h00, 8'h28);
    wr(8'h01, 8'ha5);
    wr(8'h02, 8'h3c);
    wr(8'h03, 8'hff);
    rdc(8'h03, 8'h00);
    rdc(8'h0c, 8'h00);
    wr(8'h08, 8'hff);
    settle;
    chk_oe(exp_reg(8'h28, 8'ha5, 8'h3c, 8'h00));
    pin_n = 8'h81;
    settle;
    chk_oe(exp_reg(8'h28, 8'ha5, 8'h3c, 8'h81));
    rdc(8'h03, 8'h81);
    rdc(8'h04, 8'h00);
    wr(8'h08, 8'h00);
  endtask

  task automatic t_sideband;
    sel = 1'b1;
    settle;
    sbm.send(20'h5a3c9);
    settle;
    chk_oe(20'h5a3c9);
    rdc(8'h04, 8'h01);
    pin_n = 8'hff;
    sbm.stray(3);
    sbm.reload;
    settle;
    chk_oe(20'h5a3c9);
    wr(8'h08, 8'h0f);
    wr(8'h0a, 8'h0c);
    settle;
    chk_oe(20'h5a3c9 | 20'hc000f);
    sbm.send(20'h00000);
    settle;
    chk_oe(20'hc000f);
    sel = 1'b0;
    pin_n = 8'h00;
    settle;
    chk_oe(exp_reg(8'h28, 8'ha5, 8'h3c, 8'h00));
  endtask

  initial begin
    #500us;
    err_total++;
    test_done;
  end

  initial begin
    repeat (2) @(posedge sys_clk);
    #DLY nrst = 1'b1;
    t_reset;
    t_regs;
    t_sideband;
    test_done;
  end
endmodule // clk_oe_prog_test

// >>> bench/sb_ctrl_model.sv
// board controller model driving the three-wire sideband port
`timescale 1ns/1ps
module sb_ctrl_model (
  output clk_oe_pkg::sideband_pins_t sb
);
  localparam int HALF = 80;
  // clock stands low outside frames
  initial sb = '0;
  // msb first, so the first bit shifted lands on channel 19
  task automatic send(input logic [19:0] word);
    sb.shift_load_n = 1'b1;
    for (int i = 19; i >= 0; i--) begin
      sb.data = word[i];
      #HALF sb.clk = 1'b1;
      #HALF sb.clk = 1'b0;
    end
    #HALF sb.shift_load_n = 1'b0;
    // released data line must not keep its last level
    #HALF sb.data = ~sb.data;
  endtask
  // strobe pulse without clocks: copies the shift register as it stands into the output register
  task automatic reload;
    sb.shift_load_n = 1'b1;
    #HALF sb.shift_load_n = 1'b0;
    #HALF;
  endtask
  // clock pulses with strobe low, to be ignored by the device
  task automatic stray(input int n);
    repeat (n) begin
      sb.data = ~sb.data;
      #HALF sb.clk = 1'b1;
      #HALF sb.clk = 1'b0;
    end
  endtask
endmodule // sb_ctrl_model

// >>> logic/clk_oe_pkg.sv
// shared constants and types for the clock output enable programming block
package clk_oe_pkg;
  localparam int unsigned NUM_CH = 20;
  localparam int unsigned NUM_HW_PINS = 8;
  localparam int unsigned HW_PIN_BASE = 5;

  localparam logic [7:0] OFS_EN_HI = 8'h00;
  localparam logic [7:0] OFS_EN_LOW = 8'h01;
  localparam logic [7:0] OFS_EN_MID = 8'h02;
  localparam logic [7:0] OFS_PIN_RDBK = 8'h03;
  localparam logic [7:0] OFS_SEL_RDBK = 8'h04;
  localparam logic [7:0] OFS_VDR_REV = 8'h05;
  localparam logic [7:0] OFS_DEV_ID = 8'h06;
  localparam logic [7:0] OFS_RD_CNT = 8'h07;
  localparam logic [7:0] OFS_MASK_A = 8'h08;
  localparam logic [7:0] OFS_MASK_B = 8'h09;
  localparam logic [7:0] OFS_MASK_C = 8'h0a;

  localparam logic [7:0] RST_EN_HI = 8'h78;
  localparam logic [7:0] RST_EN_LOW = 8'hff;
  localparam logic [7:0] RST_EN_MID = 8'hff;
  localparam logic [7:0] RST_RD_CNT = 8'h08;
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] EN_HI_MASK = 8'h78;
  localparam logic [7:0] RD_CNT_MASK = 8'h3f;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // arbitrary identification values
  localparam logic [7:0] VDR_REV_VAL = 8'h1a;
  localparam logic [7:0] DEV_ID_VAL = 8'h5c;

  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic data;
    logic clk;
    logic shift_load_n;
  } sideband_pins_t;
endpackage

// >>> logic/clk_oe_prog.sv
// clock output enable programming: register bank, sideband port, mux
`timescale 1ns/1ps
// How it works
// - select pin high: enables come from the sideband serial port.
// - select pin low: enables come from the register path only.
// - override masks act only while the sideband port is selected.
// - a set mask bit forces its channel enabled, bypassing sideband data.
// - strobe high: each sideband clock rise shifts data in.
// - strobe falling edge copies shift register into sideband output reg.
// - both paths pass common resync that switches without runt pulses.
// - each of 20 channels has its own enable in either mode.
// - enable bytes at 0..2, pin readback 3, select readback 4.
// - vendor/revision at 5, device id at 6, read count at 7.
// - override masks at 8, 9 and a.
// - first byte bits 6..3 drive channels 19..16; 1 enables.
// - first byte resets to 78h; bit 7 and bits 2..0 read zero.
// - second byte bits 7..0 drive channels 7..0.
// - second byte resets to ffh.
// - shift and output registers are 20 bits each.
// - sideband mode: three enable pins carry port, others disabled.
// - register mode: channels 5..12 need bit set and pin low.
// - sideband port works regardless of the power-good pin.
module clk_oe_prog #(
  parameter int unsigned NUM_CH = clk_oe_pkg::NUM_CH
) (
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 ref_clk,
  input  wire logic                 interface_select_pin,
  input  wire logic [7:0]           hw_oe_n,
  input  wire clk_oe_pkg::reg_req_t reg_req,
  output logic      [7:0]           reg_rdata,
  output logic      [NUM_CH-1:0]    clock_output_channel
);
  // synchronisers for pin inputs
  logic [7:0] oe1_ff;
  logic [7:0] oe2_ff;
  logic       sel1_ff;
  logic       sel2_ff;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      oe1_ff  <= 8'hff;
      oe2_ff  <= 8'hff;
      sel1_ff <= 1'b0;
      sel2_ff <= 1'b0;
    end else begin
      oe1_ff  <= hw_oe_n;
      oe2_ff  <= oe1_ff;
      sel1_ff <= interface_select_pin;
      sel2_ff <= sel1_ff;
    end
  end

  // sideband pins ride on hardware enable pins 5, 6 and 10
  clk_oe_pkg::sideband_pins_t sb;
  always_comb begin
    sb.data         = oe2_ff[0];
    sb.clk          = oe2_ff[1];
    sb.shift_load_n = oe2_ff[5];
  end

  // sideband shift / output registers, edge detected on sys_clk
  logic [NUM_CH-1:0] shift_ff;
  logic [NUM_CH-1:0] sb_out_ff;
  logic              sbclk_d_ff;
  logic              strobe_d_ff;
  logic [NUM_CH-1:0] nxt_shift;
  logic [NUM_CH-1:0] nxt_sb_out;
  logic              sbclk_rise;
  logic              strobe_fall;

  always_comb begin
    sbclk_rise  = sb.clk & ~sbclk_d_ff;
    strobe_fall = ~sb.shift_load_n & strobe_d_ff;
    nxt_shift   = shift_ff;
    nxt_sb_out  = sb_out_ff;
    // no power-good gating: works before first power good
    if (sel2_ff && sb.shift_load_n && sbclk_rise) begin
      nxt_shift = {shift_ff[NUM_CH-2:0], sb.data};
    end
    if (sel2_ff && strobe_fall) begin
      nxt_sb_out = shift_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shift_ff    <= '0;
      sb_out_ff   <= '0;
      sbclk_d_ff  <= 1'b0;
      strobe_d_ff <= 1'b0;
    end else begin
      shift_ff    <= nxt_shift;
      sb_out_ff   <= nxt_sb_out;
      sbclk_d_ff  <= sb.clk;
      strobe_d_ff <= sb.shift_load_n;
    end
  end

  // register bank
  logic [7:0] en_hi_ff;
  logic [7:0] en_low_ff;
  logic [7:0] en_mid_ff;
  logic [7:0] rd_cnt_ff;
  logic [7:0] mask_a_ff;
  logic [7:0] mask_b_ff;
  logic [7:0] mask_c_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_en_hi;
  logic [7:0] nxt_en_low;
  logic [7:0] nxt_en_mid;
  logic [7:0] nxt_rd_cnt;
  logic [7:0] nxt_mask_a;
  logic [7:0] nxt_mask_b;
  logic [7:0] nxt_mask_c;
  logic [7:0] nxt_rdata;

  function automatic logic hit(input clk_oe_pkg::reg_req_t r,
                               input logic [7:0] ofs);
    return r.wr_en && (r.addr == ofs);
  endfunction

  always_comb begin
    nxt_en_hi  = en_hi_ff;
    nxt_en_low = en_low_ff;
    nxt_en_mid = en_mid_ff;
    nxt_rd_cnt = rd_cnt_ff;
    nxt_mask_a = mask_a_ff;
    nxt_mask_b = mask_b_ff;
    nxt_mask_c = mask_c_ff;
    if (hit(reg_req, clk_oe_pkg::OFS_EN_HI)) begin
      nxt_en_hi = reg_req.wdata & clk_oe_pkg::EN_HI_MASK;
    end else if (hit(reg_req, clk_oe_pkg::OFS_EN_LOW)) begin
      nxt_en_low = reg_req.wdata;
    end else if (hit(reg_req, clk_oe_pkg::OFS_EN_MID)) begin
      nxt_en_mid = reg_req.wdata;
    end else if (hit(reg_req, clk_oe_pkg::OFS_RD_CNT)) begin
      nxt_rd_cnt = reg_req.wdata & clk_oe_pkg::RD_CNT_MASK;
    end else if (hit(reg_req, clk_oe_pkg::OFS_MASK_A)) begin
      nxt_mask_a = reg_req.wdata;
    end else if (hit(reg_req, clk_oe_pkg::OFS_MASK_B)) begin
      nxt_mask_b = reg_req.wdata;
    end else if (hit(reg_req, clk_oe_pkg::OFS_MASK_C)) begin
      nxt_mask_c = reg_req.wdata;
    end
    // other offsets: write dropped
  end

  // read data is registered, valid one cycle after the address
  always_comb begin
    if (reg_req.addr == clk_oe_pkg::OFS_EN_HI) begin
      nxt_rdata = en_hi_ff;
    end else if (reg_req.addr == clk_oe_pkg::OFS_EN_LOW) begin
      nxt_rdata = en_low_ff;
    end else if (reg_req.addr == clk_oe_pkg::OFS_EN_MID) begin
      nxt_rdata = en_mid_ff;
    end else if (reg_req.addr == clk_oe_pkg::OFS_PIN_RDBK) begin
      nxt_rdata = oe2_ff;
    end else if (reg_req.addr == clk_oe_pkg::OFS_SEL_RDBK) begin
      nxt_rdata = {7'h00, sel2_ff};
    end else if (reg_req.addr == clk_oe_pkg::OFS_VDR_REV) begin
      nxt_rdata = clk_oe_pkg::VDR_REV_VAL;
    end else if (reg_req.addr == clk_oe_pkg::OFS_DEV_ID) begin
      nxt_rdata = clk_oe_pkg::DEV_ID_VAL;
    end else if (reg_req.addr == clk_oe_pkg::OFS_RD_CNT) begin
      nxt_rdata = rd_cnt_ff;
    end else if (reg_req.addr == clk_oe_pkg::OFS_MASK_A) begin
      nxt_rdata = mask_a_ff;
    end else if (reg_req.addr == clk_oe_pkg::OFS_MASK_B) begin
      nxt_rdata = mask_b_ff;
    end else if (reg_req.addr == clk_oe_pkg::OFS_MASK_C) begin
      nxt_rdata = mask_c_ff;
    end else begin
      nxt_rdata = clk_oe_pkg::ZERO_BYTE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      en_hi_ff  <= clk_oe_pkg::RST_EN_HI;
      en_low_ff <= clk_oe_pkg::RST_EN_LOW;
      en_mid_ff <= clk_oe_pkg::RST_EN_MID;
      rd_cnt_ff <= clk_oe_pkg::RST_RD_CNT;
      mask_a_ff <= clk_oe_pkg::RST_MASK;
      mask_b_ff <= clk_oe_pkg::RST_MASK;
      mask_c_ff <= clk_oe_pkg::RST_MASK;
      rdata_ff  <= clk_oe_pkg::ZERO_BYTE;
    end else begin
      en_hi_ff  <= nxt_en_hi;
      en_low_ff <= nxt_en_low;
      en_mid_ff <= nxt_en_mid;
      rd_cnt_ff <= nxt_rd_cnt;
      mask_a_ff <= nxt_mask_a;
      mask_b_ff <= nxt_mask_b;
      mask_c_ff <= nxt_mask_c;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // enable selection
  logic [NUM_CH-1:0] smb_en;
  logic [NUM_CH-1:0] pin_en;
  logic [NUM_CH-1:0] mask_vec;
  logic [NUM_CH-1:0] sel_en;

  always_comb begin
    // channels 19..16 from bits 6..3, 15..8 mid byte, 7..0 low byte
    smb_en   = {en_hi_ff[6:3], en_mid_ff, en_low_ff};
    pin_en   = '1;
    pin_en[clk_oe_pkg::HW_PIN_BASE +: clk_oe_pkg::NUM_HW_PINS] = ~oe2_ff;
    mask_vec = {mask_c_ff[3:0], mask_b_ff, mask_a_ff};
    if (sel2_ff) begin
      sel_en = sb_out_ff | mask_vec;
    end else begin
      sel_en = smb_en & pin_en;
    end
  end

  logic [NUM_CH-1:0] gate_en;
  glitchless_gate #(
    .WIDTH (NUM_CH)
  ) u_gate (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ref_clk (ref_clk),
    .en_req  (sel_en),
    .en_out  (gate_en)
  );

  assign clock_output_channel = gate_en;

  a_shift_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sb.shift_load_n |=> shift_ff == $past(shift_ff))
    else $error("shift register moved while strobe low");
  a_shift_step: assert property (@(posedge sys_clk) disable iff (!nrst)
    sel2_ff && sb.shift_load_n && sbclk_rise
      |=> shift_ff[0] == $past(sb.data))
    else $error("sideband bit not shifted in");
  a_load_copy: assert property (@(posedge sys_clk) disable iff (!nrst)
    sel2_ff && strobe_fall |=> sb_out_ff == $past(shift_ff))
    else $error("output register not loaded on strobe fall");
  a_out_stable: assert property (@(posedge sys_clk) disable iff (!nrst)
    !strobe_fall |=> sb_out_ff == $past(sb_out_ff))
    else $error("output register changed without strobe fall");
  a_hi_reserved: assert property (@(posedge sys_clk) disable iff (!nrst)
    (en_hi_ff & ~clk_oe_pkg::EN_HI_MASK) == 8'h00)
    else $error("reserved bits of first enable byte set");
  a_mask_force: assert property (@(posedge sys_clk) disable iff (!nrst)
    sel2_ff |-> (sel_en & mask_vec) == mask_vec)
    else $error("masked channel not forced on");
  a_smb_path: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sel2_ff |-> sel_en == (smb_en & pin_en))
    else $error("register path not in control");
  a_pin_gate: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sel2_ff && oe2_ff[0] |-> !sel_en[5])
    else $error("channel 5 on with pin high");
  a_unmapped_rd: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_req.addr > clk_oe_pkg::OFS_MASK_C |=> rdata_ff == 8'h00)
    else $error("reserved offset read nonzero");

  // sideband path: whole-word shift and idle behaviour
  a_shift_full: assert property (@(posedge sys_clk) disable iff (!nrst)
    sel2_ff && sb.shift_load_n && sbclk_rise |=> shift_ff ==
      {$past(shift_ff[NUM_CH-2:0]), $past(sb.data)})
    else $error("shift register did not move by one bit");
  a_shift_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sel2_ff |=> shift_ff == $past(shift_ff))
    else $error("shift register moved in register mode");
  a_sbout_off: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sel2_ff |=> sb_out_ff == $past(sb_out_ff))
    else $error("sideband output changed in register mode");
  a_sb_select: assert property (@(posedge sys_clk) disable iff (!nrst)
    sel2_ff |-> sel_en == (sb_out_ff | mask_vec))
    else $error("sideband path not in control");

  // register bank: writes land, reads return the right byte
  a_hi_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    hit(reg_req, clk_oe_pkg::OFS_EN_HI) |=> en_hi_ff ==
      ($past(reg_req.wdata) & clk_oe_pkg::EN_HI_MASK))
    else $error("first enable byte write wrong");
  a_low_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    hit(reg_req, clk_oe_pkg::OFS_EN_LOW)
      |=> en_low_ff == $past(reg_req.wdata))
    else $error("second enable byte write wrong");
  a_mask_write: assert property (@(posedge sys_clk) disable iff (!nrst)
    hit(reg_req, clk_oe_pkg::OFS_MASK_C)
      |=> mask_c_ff == $past(reg_req.wdata))
    else $error("override mask write wrong");
  a_pin_rdbk: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_req.addr == clk_oe_pkg::OFS_PIN_RDBK
      |=> rdata_ff == $past(oe2_ff))
    else $error("pin readback wrong");
  a_sel_rdbk: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_req.addr == clk_oe_pkg::OFS_SEL_RDBK
      |=> rdata_ff == {7'h00, $past(sel2_ff)})
    else $error("select readback wrong");
  a_dev_id_rd: assert property (@(posedge sys_clk) disable iff (!nrst)
    reg_req.addr == clk_oe_pkg::OFS_DEV_ID
      |=> rdata_ff == clk_oe_pkg::DEV_ID_VAL)
    else $error("device id read wrong");

  // register mode channel mapping
  a_hi_map: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sel2_ff |-> sel_en[NUM_CH-1 -: 4] == en_hi_ff[6:3])
    else $error("channels 19..16 not from first byte");
  a_low_map: assert property (@(posedge sys_clk) disable iff (!nrst)
    !sel2_ff |-> sel_en[4:0] == en_low_ff[4:0])
    else $error("channels 4..0 not from second byte");
endmodule // clk_oe_prog

// >>> logic/glitchless_gate.sv
// per-channel enable resync that switches only while the output clock is low
`timescale 1ns/1ps
module glitchless_gate #(
  parameter int unsigned WIDTH = 20
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic             ref_clk,
  input  wire logic [WIDTH-1:0] en_req,
  output logic      [WIDTH-1:0] en_out
);
  logic [WIDTH-1:0] sync1_ff;
  logic [WIDTH-1:0] sync2_ff;
  logic [WIDTH-1:0] en_ff;
  logic [WIDTH-1:0] nxt_en;
  logic             ref1_ff;
  logic             ref2_ff;

  // update only in the low phase of the buffered clock: no runt pulse
  always_comb begin
    nxt_en = en_ff;
    if (!ref2_ff) begin
      nxt_en = sync2_ff;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      en_ff    <= '0;
      ref1_ff  <= 1'b0;
      ref2_ff  <= 1'b0;
    end else begin
      sync1_ff <= en_req;
      sync2_ff <= sync1_ff;
      en_ff    <= nxt_en;
      ref1_ff  <= ref_clk;
      ref2_ff  <= ref1_ff;
    end
  end

  assign en_out = en_ff;

  a_gate_hold_high: assert property (@(posedge sys_clk) disable iff (!nrst)
    ref2_ff |=> en_ff == $past(en_ff))
    else $error("enable changed during clock high phase");
endmodule // glitchless_gate
